/* File: src/sec_pkg.sv */
/*
 * Shared constants and types for the serial EEPROM command and
 * write-protection block: geometry, opcodes, status layout, reset values,
 * protection bounds and the self-timed write cycle length.
 * Assumes a single 250 MHz system clock in the block that uses it.
 */
package sec_pkg;
    // Array geometry
    localparam int          ADDR_W      = 11;
    localparam int          ARRAY_BYTES = 2048;
    localparam int          PAGE_W      = 5;
    localparam int          PAGE_BYTES  = 32;

    // Opcode: upper nibble zero, bit 3 ignored, low three bits select
    localparam logic [3:0]  OPC_UPPER     = 4'h0;
    localparam logic [2:0]  OPC_SET_LATCH = 3'h6;
    localparam logic [2:0]  OPC_CLR_LATCH = 3'h4;
    localparam logic [2:0]  OPC_STAT_RD   = 3'h5;
    localparam logic [2:0]  OPC_STAT_WR   = 3'h1;
    localparam logic [2:0]  OPC_ARR_RD    = 3'h3;
    localparam logic [2:0]  OPC_ARR_WR    = 3'h2;

    // Status register layout
    localparam int          ST_PEN_BIT  = 7;
    localparam int          ST_BPH_BIT  = 3;
    localparam int          ST_BPL_BIT  = 2;
    localparam int          ST_WEL_BIT  = 1;
    localparam int          ST_BUSY_BIT = 0;
    localparam logic [7:0]  ST_WHILE_BUSY = 8'hff;

    // Reset values
    localparam logic        RST_PEN = 1'h0;
    localparam logic [1:0]  RST_BP  = 2'h0;
    localparam logic        RST_WEL = 1'h0;

    // Block-protect codes and protected-region bases
    localparam logic [1:0]  BP_NONE    = 2'h0;
    localparam logic [1:0]  BP_QUARTER = 2'h1;
    localparam logic [1:0]  BP_HALF    = 2'h2;
    localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 11'h600;
    localparam logic [ADDR_W-1:0] PROT_HALF_BASE    = 11'h400;

    // Self-timed write cycle
    localparam int unsigned WRITE_CYCLE_NS     = 5000000;
    localparam int unsigned CLK_PERIOD_NS      = 4;
    localparam int unsigned WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / CLK_PERIOD_NS;

    typedef enum {
        SEC_OPCODE,
        SEC_SET_WAIT,
        SEC_CLR_WAIT,
        SEC_STAT_OUT,
        SEC_STAT_IN,
        SEC_RD_ADDR,
        SEC_ARR_OUT,
        SEC_WR_ADDR,
        SEC_WR_DATA,
        SEC_IGNORE
    } sec_state_t;
endpackage

/* File: src/sec_sync.sv */
/*
 * Two-flip-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to clk_in; only the second stage is used.
 */
`timescale 1ns/1ps
module sec_sync #(
    parameter logic RESET_VAL = 1'h0
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta      <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            meta      <= pin_in;
            level_out <= meta;
        end
    end
endmodule

/* File: src/sec_buf2.sv */
/*
 * Two-entry buffer with valid/ready on both sides and a synchronous flush.
 * Assumes source and sink are on clk_in; flush wins over a push.
 */
`timescale 1ns/1ps
module sec_buf2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             flush_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    logic [WIDTH-1:0] slot [2];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out  = slot[rd_ptr];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_ready_in & out_valid_out;

    always_ff @(posedge clk_in) begin
        if (push) begin
            slot[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= 1'h0;
            rd_ptr <= 1'h0;
            count  <= 2'h0;
        end else if (flush_in) begin
            wr_ptr <= 1'h0;
            rd_ptr <= 1'h0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule

/* File: src/sec_eeprom.sv */
/*
 * Serial EEPROM slave: 2048x8 array, status register, command decode,
 * write-enable latch, block and hardware write protection, page write and
 * self-timed write cycle with busy lockout.
 * Assumes the SPI pins and the write-protect pin are asynchronous to clk_in
 * and that the serial clock runs well below a quarter of clk_in.
 */
`timescale 1ns/1ps
module sec_eeprom #(
    parameter int unsigned WRITE_CYCLES = sec_pkg::WRITE_CYCLE_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       spi_cs_n_in,
    input  wire logic       spi_sck_in,
    input  wire logic       spi_si_in,
    input  wire logic       wp_n_in,
    output logic            spi_so_out,
    output logic            spi_so_oe_out,
    output logic            busy_out,
    output logic [7:0]      status_out
);
    localparam int AW = sec_pkg::ADDR_W;

    sec_pkg::sec_state_t state;

    logic            cs_n_s;
    logic            sck_s;
    logic            si_s;
    logic            wp_n_s;
    logic            cs_n_d;
    logic            sck_d;
    logic            active;
    logic            sck_rise;
    logic            sck_fall;
    logic            cs_end;

    logic [6:0]      rx_shift;
    logic [2:0]      rx_cnt;
    logic [1:0]      phase;
    logic [7:0]      rx_byte;
    logic            byte_done;
    logic            op_ok;
    logic [2:0]      op_sel;
    logic [2:0]      addr_hi;
    logic [AW-1:0]   full_addr;
    logic [7:0]      stat_data;

    logic            wel;
    logic            pen;
    logic [1:0]      bp;
    logic            hw_prot;
    logic            pen_new;
    logic [1:0]      bp_new;
    logic            busy;
    logic [31:0]     timer;
    logic            pend_stat;

    logic [7:0]      page_mem [sec_pkg::PAGE_BYTES];
    logic [sec_pkg::PAGE_BYTES-1:0] page_vld;
    logic [AW-1:sec_pkg::PAGE_W]    wr_base;
    logic [sec_pkg::PAGE_W-1:0]     wr_ofs;
    logic            commit_run;
    logic [sec_pkg::PAGE_W-1:0]     commit_idx;
    logic [AW-1:0]   commit_addr;
    logic            commit_we;

    logic [7:0]      mem [sec_pkg::ARRAY_BYTES];
    logic [AW-1:0]   fetch_addr;
    logic            fetch_on;
    logic            buf_in_ready;
    logic            buf_out_valid;
    logic [7:0]      buf_out_data;
    logic            buf_pop;

    logic [6:0]      tx_shift;
    logic [2:0]      out_cnt;
    logic            so_on;
    logic [7:0]      load_byte;
    logic [7:0]      status_rd;

    logic            set_ok;
    logic            clr_ok;
    logic            sw_form;
    logic            aw_form;
    logic            sw_go;
    logic            aw_go;
    logic            aligned;

    function automatic logic in_block(input logic [AW-1:0] a, input logic [1:0] code);
        logic hit;
        hit = 1'h1;
        if (code == sec_pkg::BP_NONE) begin
            hit = 1'h0;
        end else if (code == sec_pkg::BP_QUARTER) begin
            hit = (a >= sec_pkg::PROT_QUARTER_BASE);
        end else if (code == sec_pkg::BP_HALF) begin
            hit = (a >= sec_pkg::PROT_HALF_BASE);
        end
        return hit;
    endfunction

    // Pin synchronisers
    sec_sync #(.RESET_VAL(1'h1)) u_sync_cs (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (spi_cs_n_in),
        .level_out (cs_n_s)
    );
    sec_sync #(.RESET_VAL(1'h0)) u_sync_sck (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (spi_sck_in),
        .level_out (sck_s)
    );
    sec_sync #(.RESET_VAL(1'h0)) u_sync_si (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (spi_si_in),
        .level_out (si_s)
    );
    sec_sync #(.RESET_VAL(1'h1)) u_sync_wp (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (wp_n_in),
        .level_out (wp_n_s)
    );

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_n_d <= 1'h1;
            sck_d  <= 1'h0;
        end else begin
            cs_n_d <= cs_n_s;
            sck_d  <= sck_s;
        end
    end

    assign active   = ~cs_n_s;
    assign sck_rise = active & sck_s & ~sck_d;
    assign sck_fall = active & ~sck_s & sck_d;
    assign cs_end   = cs_n_s & ~cs_n_d;

    // Receive shifter
    assign rx_byte   = {rx_shift, si_s};
    assign byte_done = sck_rise & (rx_cnt == 3'h7);
    assign op_ok     = (rx_byte[7:4] == sec_pkg::OPC_UPPER);
    assign op_sel    = rx_byte[2:0];
    assign full_addr = {addr_hi, rx_byte};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_shift <= 7'h00;
            rx_cnt   <= 3'h0;
            phase    <= 2'h0;
        end else if (!active) begin
            rx_cnt <= 3'h0;
            phase  <= 2'h0;
        end else if (sck_rise) begin
            rx_shift <= rx_byte[6:0];
            rx_cnt   <= rx_cnt + 3'h1;
            if (rx_cnt == 3'h7 && phase != 2'h3) begin
                phase <= phase + 2'h1;
            end
        end
    end

    // Instruction sequencing
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= sec_pkg::SEC_OPCODE;
        end else if (!active) begin
            state <= sec_pkg::SEC_OPCODE;
        end else if (byte_done) begin
            case (state)
                sec_pkg::SEC_OPCODE: begin
                    if (!op_ok) begin
                        state <= sec_pkg::SEC_IGNORE;
                    end else if (busy && op_sel != sec_pkg::OPC_STAT_RD) begin
                        state <= sec_pkg::SEC_IGNORE;
                    end else begin
                        case (op_sel)
                            sec_pkg::OPC_SET_LATCH: state <= sec_pkg::SEC_SET_WAIT;
                            sec_pkg::OPC_CLR_LATCH: state <= sec_pkg::SEC_CLR_WAIT;
                            sec_pkg::OPC_STAT_RD:   state <= sec_pkg::SEC_STAT_OUT;
                            sec_pkg::OPC_STAT_WR:   state <= sec_pkg::SEC_STAT_IN;
                            sec_pkg::OPC_ARR_RD:    state <= sec_pkg::SEC_RD_ADDR;
                            sec_pkg::OPC_ARR_WR:    state <= sec_pkg::SEC_WR_ADDR;
                            default:                state <= sec_pkg::SEC_IGNORE;
                        endcase
                    end
                end
                sec_pkg::SEC_RD_ADDR: begin
                    if (phase == 2'h2) begin
                        state <= sec_pkg::SEC_ARR_OUT;
                    end
                end
                sec_pkg::SEC_WR_ADDR: begin
                    if (phase == 2'h2) begin
                        state <= sec_pkg::SEC_WR_DATA;
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // Address and status data capture
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_hi   <= 3'h0;
            stat_data <= 8'h00;
        end else if (byte_done) begin
            if (phase == 2'h1) begin
                addr_hi <= rx_byte[2:0];
            end
            // Status polls during busy must not overwrite the pending byte
            if (phase == 2'h1 && state == sec_pkg::SEC_STAT_IN) begin
                stat_data <= rx_byte;
            end
        end
    end

    // End-of-instruction checks on chip select rise
    assign aligned = (rx_cnt == 3'h0);
    assign set_ok  = cs_end & (state == sec_pkg::SEC_SET_WAIT) & (phase == 2'h1) & aligned;
    assign clr_ok  = cs_end & (state == sec_pkg::SEC_CLR_WAIT) & (phase == 2'h1) & aligned;
    assign sw_form = cs_end & (state == sec_pkg::SEC_STAT_IN) & (phase == 2'h2) & aligned;
    assign aw_form = cs_end & (state == sec_pkg::SEC_WR_DATA) & aligned & (|page_vld);
    assign hw_prot = ~wp_n_s & pen;
    assign sw_go   = sw_form & wel & ~hw_prot;
    assign aw_go   = aw_form & wel;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wel <= sec_pkg::RST_WEL;
        end else if (set_ok) begin
            wel <= 1'h1;
        end else if (clr_ok || sw_go || aw_go) begin
            wel <= 1'h0;
        end
    end

    // Protect-enable may only fall with the protect pin high
    assign pen_new = (pen & ~wp_n_s) | stat_data[sec_pkg::ST_PEN_BIT];
    assign bp_new  = stat_data[sec_pkg::ST_BPH_BIT:sec_pkg::ST_BPL_BIT];

    // Self-timed write cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy      <= 1'h0;
            timer     <= 32'h0;
            pend_stat <= 1'h0;
        end else if (sw_go || aw_go) begin
            busy      <= 1'h1;
            timer     <= WRITE_CYCLES;
            pend_stat <= sw_go;
        end else if (busy) begin
            timer <= timer - 32'h1;
            if (timer == 32'h1) begin
                busy      <= 1'h0;
                pend_stat <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pen <= sec_pkg::RST_PEN;
            bp  <= sec_pkg::RST_BP;
        end else if (busy && pend_stat && timer == 32'h1) begin
            pen <= pen_new;
            bp  <= bp_new;
        end
    end

    // Page buffer fill
    always_ff @(posedge clk_in) begin
        if (byte_done && state == sec_pkg::SEC_WR_DATA) begin
            page_mem[wr_ofs] <= rx_byte;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            page_vld <= '0;
            wr_base  <= '0;
            wr_ofs   <= '0;
        end else if (byte_done && state == sec_pkg::SEC_WR_ADDR && phase == 2'h2) begin
            page_vld <= '0;
            wr_base  <= full_addr[AW-1:sec_pkg::PAGE_W];
            wr_ofs   <= full_addr[sec_pkg::PAGE_W-1:0];
        end else if (byte_done && state == sec_pkg::SEC_WR_DATA) begin
            page_vld[wr_ofs] <= 1'h1;
            wr_ofs           <= wr_ofs + 5'h01;
        end
    end

    // Commit page to the array at the start of the write cycle
    assign commit_addr = {wr_base, commit_idx};
    assign commit_we   = commit_run & page_vld[commit_idx] & ~in_block(commit_addr, bp);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            commit_run <= 1'h0;
            commit_idx <= '0;
        end else if (aw_go) begin
            commit_run <= 1'h1;
            commit_idx <= '0;
        end else if (commit_run) begin
            commit_idx <= commit_idx + 5'h01;
            if (commit_idx == 5'h1f) begin
                commit_run <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (commit_we) begin
            mem[commit_addr] <= page_mem[commit_idx];
        end
    end

    // Array read prefetch into the two-entry buffer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fetch_on   <= 1'h0;
            fetch_addr <= '0;
        end else if (!active) begin
            fetch_on <= 1'h0;
        end else if (byte_done && state == sec_pkg::SEC_RD_ADDR && phase == 2'h2) begin
            fetch_on   <= 1'h1;
            fetch_addr <= full_addr;
        end else if (fetch_on && buf_in_ready) begin
            fetch_addr <= fetch_addr + 11'h001;
        end
    end

    sec_buf2 #(.WIDTH(8)) u_rd_buf (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .flush_in      (~active),
        .in_valid_in   (fetch_on),
        .in_data_in    (mem[fetch_addr]),
        .in_ready_out  (buf_in_ready),
        .out_valid_out (buf_out_valid),
        .out_data_out  (buf_out_data),
        .out_ready_in  (buf_pop)
    );

    // Transmit serializer
    always_comb begin
        status_rd                        = 8'h00;
        status_rd[sec_pkg::ST_PEN_BIT]   = pen;
        status_rd[sec_pkg::ST_BPH_BIT]   = bp[1];
        status_rd[sec_pkg::ST_BPL_BIT]   = bp[0];
        status_rd[sec_pkg::ST_WEL_BIT]   = wel;
        status_rd[sec_pkg::ST_BUSY_BIT]  = busy;
        if (busy) begin
            status_rd = sec_pkg::ST_WHILE_BUSY;
        end
    end

    assign load_byte = (state == sec_pkg::SEC_STAT_OUT) ? status_rd :
                       (buf_out_valid ? buf_out_data : 8'hff);
    assign buf_pop   = sck_fall & (state == sec_pkg::SEC_ARR_OUT) & (out_cnt == 3'h0);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            spi_so_out <= 1'h0;
            tx_shift   <= 7'h00;
            out_cnt    <= 3'h0;
            so_on      <= 1'h0;
        end else if (!active) begin
            out_cnt <= 3'h0;
            so_on   <= 1'h0;
        end else if (sck_fall && (state == sec_pkg::SEC_STAT_OUT || state == sec_pkg::SEC_ARR_OUT)) begin
            so_on <= 1'h1;
            if (out_cnt == 3'h0) begin
                spi_so_out <= load_byte[7];
                tx_shift   <= load_byte[6:0];
                out_cnt    <= 3'h7;
            end else begin
                spi_so_out <= tx_shift[6];
                tx_shift   <= {tx_shift[5:0], 1'h0};
                out_cnt    <= out_cnt - 3'h1;
            end
        end
    end

    assign spi_so_oe_out = so_on;
    assign busy_out      = busy;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_out <= 8'h00;
        end else begin
            status_out <= status_rd;
        end
    end
endmodule

/* File: bench/sec_eeprom_monitor.sv */
/* Port checks for sec_eeprom.
   Assumes a mode 0 master, so the serial clock idles low. */
`timescale 1ns/1ps
module sec_eeprom_monitor #(
    parameter int unsigned WRITE_CYCLES = 64
) (
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic       spi_cs_n_in,
    input wire logic       spi_sck_in,
    input wire logic       spi_si_in,
    input wire logic       wp_n_in,
    input wire logic       spi_so_out,
    input wire logic       spi_so_oe_out,
    input wire logic       busy_out,
    input wire logic [7:0] status_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    int unsigned run;
    // Length of the current busy stretch
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            run <= 0;
        else
            run <= busy_out ? run + 1 : 0;
    end
    reset_clear_a: assert property ($rose(rst_n_in) |-> status_out == 8'h00)
        else $error("status not clear after reset");
    busy_ones_a: assert property (busy_out && $past(busy_out) |-> status_out == 8'hff)
        else $error("status not all ones while busy");
    spare_zero_a: assert property (!busy_out && !$past(busy_out) |-> status_out[6:4] == 3'h0)
        else $error("spare status bits set");
    status_hold_a: assert property ($changed(status_out[7:2]) |-> busy_out || $past(busy_out) || $past(busy_out, 2))
        else $error("status changed outside a write cycle");
    latch_drop_a: assert property ($fell(busy_out) |-> ##2 !status_out[1])
        else $error("latch still set after write");
    cycle_len_a: assert property ($fell(busy_out) |-> run >= WRITE_CYCLES - 1 && run <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    busy_start_a: assert property ($rose(busy_out) |-> spi_cs_n_in)
        else $error("write cycle began while selected");
    oe_start_a: assert property ($rose(spi_so_oe_out) |-> !spi_cs_n_in)
        else $error("output enabled while deselected");
    out_idle_a: assert property (spi_cs_n_in [*5] |-> !spi_so_oe_out)
        else $error("output driven in standby");
    fall_edge_a: assert property (spi_so_oe_out && $past(spi_so_oe_out) && $changed(spi_so_out) |-> !spi_sck_in)
        else $error("output changed while clock high");
    cover property ($rose(busy_out));
    cover property ($rose(spi_so_oe_out));
    cover property (status_out[7] && !busy_out);
endmodule
bind sec_eeprom sec_eeprom_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) i_sec_eeprom_monitor (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .spi_cs_n_in(spi_cs_n_in), .spi_sck_in(spi_sck_in), .spi_si_in(spi_si_in),
    .wp_n_in(wp_n_in), .spi_so_out(spi_so_out), .spi_so_oe_out(spi_so_oe_out), .busy_out(busy_out),
    .status_out(status_out));

/* File: bench/sec_spi_master.sv */
/* Mode 0 serial master model.
   Assumes the data out line has a pull-up while the device releases it. */
`timescale 1ns/1ps
module sec_spi_master (
    input  wire logic clk_in,
    input  wire logic so_in,
    input  wire logic so_oe_in,
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out
);
    logic line;
    assign line = so_oe_in ? so_in : 1'h1;
    initial begin
        cs_n_out = 1'h1;
        sck_out = 1'h0;
        si_out = 1'h0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic frame(input logic [319:0] tx, input int nbits, output logic [319:0] rx);
        rx = '0;
        cs_n_out <= 1'h0;
        for (int i = nbits - 1; i >= 0; i--) begin
            wt(6);
            si_out <= tx[i];
            wt(6);
            sck_out <= 1'h1;
            rx = {rx[318:0], line};
            wt(6);
            sck_out <= 1'h0;
        end
        wt(6);
        cs_n_out <= 1'h1;
        wt(8);
        si_out <= ~si_out;
    endtask
endmodule

/* File: bench/sec_eeprom_tb.sv */
/* Self-checking bench for sec_eeprom.
   Assumes the master model in sec_spi_master and a short write cycle. */
`timescale 1ns/1ps
module sec_eeprom_tb;
    logic         clk_in   = 1'h0;
    logic         rst_n_in = 1'h0;
    logic         wp_n_in  = 1'h1;
    logic         cs_n, sck, si, so, so_oe, busy;
    logic [7:0]   stat;
    logic [319:0] rx;
    logic [7:0]   mem [int];
    int           n_errors = 0;
    int           checked  = 0;
    always #2 clk_in = ~clk_in;
    sec_eeprom #(.WRITE_CYCLES(1000)) i_sec_eeprom (.clk_in(clk_in), .rst_n_in(rst_n_in), .spi_cs_n_in(cs_n),
        .spi_sck_in(sck), .spi_si_in(si), .wp_n_in(wp_n_in), .spi_so_out(so), .spi_so_oe_out(so_oe),
        .busy_out(busy), .status_out(stat));
    sec_spi_master i_sec_spi_master (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n),
        .sck_out(sck), .si_out(si));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic xf(input logic [319:0] tx, input int n);
        i_sec_spi_master.frame(tx, n, rx);
    endtask
    task automatic status_read_cmd(input logic [7:0] exp);
        xf(320'h050000, 24);
        check("status", rx[15:8], exp);
        check("status repeat", rx[7:0], exp);
    endtask
    task automatic idle();
        int k;
        for (k = 0; k < 1200 && busy !== 1'h0; k++)
            @(posedge clk_in);
        if (k == 1200) begin
            n_errors++;
            finish_test();
        end
    endtask
    task automatic wsr(input logic [7:0] d, input logic [7:0] mid);
        xf(320'h06, 8);
        xf({8'h01, d}, 16);
        status_read_cmd(mid);
        check("busy", 8'(busy), 8'(mid == 8'hff));
        idle();
    endtask
    // Page write; model updated only when the write is expected to land
    task automatic wpage(input logic [15:0] a, input int nb, input bit ok);
        logic [319:0] tx;
        logic [7:0]   d;
        tx = {8'h02, a};
        for (int i = 0; i < nb; i++) begin
            d = 8'($urandom());
            tx = {tx[311:0], d};
            if (ok)
                mem[int'({a[10:5], 5'(a[4:0] + i)})] = d;
        end
        xf(tx, 24 + 8 * nb);
        if (ok) begin
            status_read_cmd(8'hff);
            xf(320'h06, 8);
        end
        idle();
    endtask
    task automatic rd(input logic [15:0] a, input int nb);
        xf(320'({8'h03, a}) << (8 * nb), 24 + 8 * nb);
        for (int i = 0; i < nb; i++)
            check("array", rx[8 * (nb - 1 - i) +: 8], mem[(int'(a[10:0]) + i) % 2048]);
    endtask
    initial begin
        void'($urandom(53));
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'h1;
        repeat (5) @(posedge clk_in);
        status_read_cmd(8'h00);
        xf(320'h0e, 8);
        status_read_cmd(8'h02);
        xf(320'h04, 8);
        status_read_cmd(8'h00);
        xf(320'h06, 8);
        xf(320'h00c6, 15);
        xf(320'h160000, 24);
        check("released line", rx[15:8], 8'hff);
        status_read_cmd(8'h02);
        $display("Test done: decode");
        wpage(16'hfffe, 34, 1);
        status_read_cmd(8'h00);
        rd(16'hf7e0, 32);
        wpage(16'h07e0, 2, 0);
        $display("Test done: page write");
        wsr(8'hf4, 8'hff);
        status_read_cmd(8'h84);
        xf(320'h06, 8);
        wpage(16'h07e5, 1, 0);
        rd(16'h07e0, 32);
        @(posedge clk_in) wp_n_in <= 1'h0;
        wsr(8'h00, 8'h86);
        status_read_cmd(8'h86);
        @(posedge clk_in) wp_n_in <= 1'h1;
        wsr(8'h78, 8'hff);
        status_read_cmd(8'h08);
        check("status port", stat, 8'h08);
        $display("Test done: protection");
        xf(320'h06, 8);
        wpage(16'h001e, 3, 1);
        rd(16'h001e, 2);
        rd(16'h07ff, 2);
        $display("Test done: open region");
        finish_test();
    end
endmodule
